// ==== core/pgo_pad_cell.sv ====
`timescale 1ns/10ps
module pgo_pad_cell
(
   input  wire logic func_level_i,
   input  wire logic func_oe_n_i,
   input  wire logic override_i,
   input  wire logic value_i,
   output logic      level_o,
   output logic      oe_n_o
);
   // Override: pin becomes a plain output of the value bit
   always_comb
   begin
      if (override_i)
      begin
         level_o = value_i;
         oe_n_o  = 1'b0;
      end
      else
      begin
         // Normal function keeps the pad
         level_o = func_level_i;
         oe_n_o  = func_oe_n_i;
      end
   end
endmodule

// ==== core/pgo_pkg.sv ====
// ==========================================================================
// Operation
// - Eight-bit read/write pad output-enable register at 44h; set bit makes pin output.
// - Enable bit 7 turns the signal-input pin into an output from its value bit.
// - Enable bit 6 makes clock-output pin a plain output, clock function off.
// - Enable bit 5 makes the second interface-select pin a plain output.
// - Enable bit 4 makes the first interface-select pin a plain output.
// - Enable bit 3 makes the scan clock pin a plain output.
// - Enable bit 2 makes the scan mode pin a plain output.
// - Enable bit 1 makes the scan data-in pin a plain output.
// - Enable bit 0 makes the scan data-out pin a plain output.
// - With boundary scan active, the four scan enable bits do nothing.
// - Eight-bit read/write pad output-value register at 45h, same bit order.
// - Value bit 7 is the level driven on an enabled signal-input pin.
// - Read-only pad input register at 46h returns every pin's input level.
// - Input bit 7 is signal-input pin level, bit 6 clock-output pin level.
// - Input bits 5..0: select b, select a, scan clock, mode, in, out.
package pgo_pkg;

   // ========================================================================
   // Register map
   localparam int         ADDR_W            = 9;
   localparam int         DATA_W            = 32;
   localparam int         PAD_N             = 8;
   localparam logic [6:0] IDX_OUTPUT_ENABLE = 7'h44;
   localparam logic [6:0] IDX_OUTPUT_VALUE  = 7'h45;
   localparam logic [6:0] IDX_INPUT_LEVEL   = 7'h46;
   localparam logic [7:0] RST_OUTPUT_ENABLE = 8'h00;
   localparam logic [7:0] RST_OUTPUT_VALUE  = 8'h00;

   // ========================================================================
   // Pin positions, shared by all three registers
   localparam int BIT_SIGNAL_INPUT_PIN = 7;
   localparam int BIT_CLOCK_OUTPUT_PIN = 6;
   localparam int BIT_SELECT_B         = 5;
   localparam int BIT_SELECT_A         = 4;
   localparam int BIT_SCAN_CLOCK       = 3;
   localparam int BIT_SCAN_MODE        = 2;
   localparam int BIT_SCAN_IN          = 1;
   localparam int BIT_SCAN_OUT         = 0;
   localparam logic [7:0] SCAN_PIN_MASK = 8'h0F;

   localparam logic [1:0] RESP_OKAY        = 2'h0;
   localparam logic [1:0] RESP_DECODEERROR = 2'h3;

   // ========================================================================
   // Types
   typedef enum logic [0:0]
   {
      PGO_IDLE = 1'h0,
      PGO_ACK  = 1'h1
   } pgo_bus_state_t;

   typedef struct packed
   {
      logic [PAD_N-1:0] level;
      logic [PAD_N-1:0] oe_n;
   } pgo_pad_drive_t;

endpackage

// ==== core/pgo_reg_byte.sv ====
`timescale 1ns/10ps
module pgo_reg_byte
#(
   parameter int         W   = 8,
   parameter logic [7:0] RST = 8'h00
)
(
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         we_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] next_q;

   always_comb
   begin
      next_q = q_o;
      if (we_i)
      begin
         next_q = d_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q_o <= RST[W-1:0];
      end
      else
      begin
         q_o <= next_q;
      end
   end
endmodule

// ==== core/pgo_top.sv ====
`timescale 1ns/10ps
module pgo_top
(
   input  wire logic                        CLK_SYS_I,
   input  wire logic                        NRST_I,
   // Avalon-MM slave
   input  wire logic [pgo_pkg::ADDR_W-1:0]  AVS_ADDRESS_I,
   input  wire logic                        AVS_READ_I,
   input  wire logic                        AVS_WRITE_I,
   input  wire logic [pgo_pkg::DATA_W-1:0]  AVS_WRITEDATA_I,
   input  wire logic [3:0]                  AVS_BYTEENABLE_I,
   output logic      [pgo_pkg::DATA_W-1:0]  AVS_READDATA_O,
   output logic      [1:0]                  AVS_RESPONSE_O,
   output logic                             AVS_WAITREQUEST_O,
   // Boundary scan strap from the nonvolatile configuration
   input  wire logic                        SCAN_ACTIVE_I,
   // Normal pin functions
   input  wire pgo_pkg::pgo_pad_drive_t     FUNC_DRIVE_I,
   output logic      [pgo_pkg::PAD_N-1:0]   FUNC_LEVEL_O,
   output logic      [pgo_pkg::PAD_N-1:0]   PIN_OVERRIDE_O,
   output logic                             CLOCK_OUTPUT_ON_O,
   // Pads
   input  wire logic [pgo_pkg::PAD_N-1:0]   PAD_IN_I,
   output pgo_pkg::pgo_pad_drive_t          PAD_DRIVE_O
);
   import pgo_pkg::*;

   // ========================================================================
   // Reset release
   // Asserts at once and releases two edges later, so no flop leaves reset alone
   logic       rst_meta;
   logic       rst_n;
   logic       next_rst_meta;
   logic       next_rst_n;

   always_comb
   begin
      next_rst_meta = 1'b1;
      next_rst_n    = rst_meta;
   end

   always_ff @(posedge CLK_SYS_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= next_rst_meta;
         rst_n    <= next_rst_n;
      end
   end

   // ========================================================================
   // Bus handshake
   // One wait cycle: the request is latched in idle and answered in ack,
   // which keeps read data registered at the cost of one extra cycle.
   pgo_bus_state_t    state;
   pgo_bus_state_t    next_state;
   logic [6:0]        req_index;
   logic [6:0]        next_req_index;
   logic              req_write;
   logic              next_req_write;
   logic              req_lane0;
   logic              next_req_lane0;
   logic [7:0]        req_data;
   logic [7:0]        next_req_data;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] next_rdata;
   logic [1:0]        resp;
   logic [1:0]        next_resp;

   logic [7:0]        output_enable;
   logic [7:0]        output_value;
   logic [7:0]        input_level;
   logic              live_hit;
   logic [7:0]        live_byte;
   logic              we_enable;
   logic              we_value;

   // Live decode for the read path
   always_comb
   begin
      live_hit  = 1'b1;
      live_byte = 8'h00;
      unique case (AVS_ADDRESS_I[ADDR_W-1:2])
         IDX_OUTPUT_ENABLE:
         begin
            live_byte = output_enable;
         end
         IDX_OUTPUT_VALUE:
         begin
            live_byte = output_value;
         end
         IDX_INPUT_LEVEL:
         begin
            live_byte = input_level;
         end
         default:
         begin
            live_hit  = 1'b0;
         end
      endcase
   end

   always_comb
   begin
      next_state     = state;
      next_req_index = req_index;
      next_req_write = req_write;
      next_req_lane0 = req_lane0;
      next_req_data  = req_data;
      next_rdata     = rdata;
      next_resp      = resp;
      unique case (state)
         PGO_IDLE:
         begin
            if (AVS_READ_I || AVS_WRITE_I)
            begin
               next_state     = PGO_ACK;
               next_req_index = AVS_ADDRESS_I[ADDR_W-1:2];
               next_req_write = AVS_WRITE_I;
               next_req_lane0 = AVS_BYTEENABLE_I[0];
               next_req_data  = AVS_WRITEDATA_I[7:0];
               next_rdata     = '0;
               next_resp      = live_hit ? RESP_OKAY : RESP_DECODEERROR;
               if (AVS_READ_I)
               begin
                  // Upper bits read as zero
                  next_rdata = {{(DATA_W-8){1'b0}}, live_byte};
               end
            end
         end
         PGO_ACK:
         begin
            // A request still held in the idle cycle after ack is taken again at the edge that ends it;
            // the master must drop it on the edge that ends the wait
            next_state = PGO_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state     <= PGO_IDLE;
         req_index <= 7'h00;
         req_write <= 1'b0;
         req_lane0 <= 1'b0;
         req_data  <= 8'h00;
         rdata     <= '0;
         resp      <= RESP_OKAY;
      end
      else
      begin
         state     <= next_state;
         req_index <= next_req_index;
         req_write <= next_req_write;
         req_lane0 <= next_req_lane0;
         req_data  <= next_req_data;
         rdata     <= next_rdata;
         resp      <= next_resp;
      end
   end

   always_comb
   begin
      AVS_WAITREQUEST_O = (state != PGO_ACK);
      AVS_READDATA_O    = rdata;
      AVS_RESPONSE_O    = resp;
   end

   // ========================================================================
   // Registers
   // Writes land on the edge that ends the wait; lane 0 carries the byte.
   always_comb
   begin
      we_enable = 1'b0;
      we_value  = 1'b0;
      // Byte lane 0 must be enabled; the other lanes hold nothing
      if ((state == PGO_ACK) && req_write && req_lane0)
      begin
         unique case (req_index)
            IDX_OUTPUT_ENABLE:
            begin
               we_enable = 1'b1;
            end
            IDX_OUTPUT_VALUE:
            begin
               we_value  = 1'b1;
            end
            default:
            begin
               // Input register and unmapped indices store nothing
               we_enable = 1'b0;
            end
         endcase
      end
   end

   pgo_reg_byte
   #(
      .W   (8),
      .RST (RST_OUTPUT_ENABLE)
   )
   u_output_enable
   (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .we_i    (we_enable),
      .d_i     (req_data),
      .q_o     (output_enable)
   );

   pgo_reg_byte
   #(
      .W   (8),
      .RST (RST_OUTPUT_VALUE)
   )
   u_output_value
   (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .we_i    (we_value),
      .d_i     (req_data),
      .q_o     (output_value)
   );

   // ========================================================================
   // Pin override
   // Scan pins stay with the scan logic while the strap says so; the
   // enable bits are still stored and read back unchanged.
   logic [PAD_N-1:0] override;

   always_comb
   begin
      override = output_enable;
      override[BIT_SIGNAL_INPUT_PIN] = output_enable[BIT_SIGNAL_INPUT_PIN];
      override[BIT_CLOCK_OUTPUT_PIN] = output_enable[BIT_CLOCK_OUTPUT_PIN];
      override[BIT_SELECT_B]         = output_enable[BIT_SELECT_B];
      override[BIT_SELECT_A]         = output_enable[BIT_SELECT_A];
      override[BIT_SCAN_CLOCK]       = output_enable[BIT_SCAN_CLOCK];
      override[BIT_SCAN_MODE]        = output_enable[BIT_SCAN_MODE];
      override[BIT_SCAN_IN]          = output_enable[BIT_SCAN_IN];
      override[BIT_SCAN_OUT]         = output_enable[BIT_SCAN_OUT];
      if (SCAN_ACTIVE_I)
      begin
         // Scan logic keeps these four pins
         override[BIT_SCAN_CLOCK] = 1'b0;
         override[BIT_SCAN_MODE]  = 1'b0;
         override[BIT_SCAN_IN]    = 1'b0;
         override[BIT_SCAN_OUT]   = 1'b0;
      end
   end

   genvar g;
   generate
      for (g = 0; g < PAD_N; g++)
      begin : g_pad
         // Value bit drives only an overridden pin
         pgo_pad_cell u_cell
         (
            .func_level_i (FUNC_DRIVE_I.level[g]),
            .func_oe_n_i  (FUNC_DRIVE_I.oe_n[g]),
            .override_i   (override[g]),
            .value_i      (output_value[g]),
            .level_o      (PAD_DRIVE_O.level[g]),
            .oe_n_o       (PAD_DRIVE_O.oe_n[g])
         );
      end
   endgenerate

   // ========================================================================
   // Input buffers
   always_comb
   begin
      // Same bit order as the enable register
      input_level[BIT_SIGNAL_INPUT_PIN] = PAD_IN_I[BIT_SIGNAL_INPUT_PIN];
      input_level[BIT_CLOCK_OUTPUT_PIN] = PAD_IN_I[BIT_CLOCK_OUTPUT_PIN];
      input_level[BIT_SELECT_B]         = PAD_IN_I[BIT_SELECT_B];
      input_level[BIT_SELECT_A]         = PAD_IN_I[BIT_SELECT_A];
      input_level[BIT_SCAN_CLOCK]       = PAD_IN_I[BIT_SCAN_CLOCK];
      input_level[BIT_SCAN_MODE]        = PAD_IN_I[BIT_SCAN_MODE];
      input_level[BIT_SCAN_IN]          = PAD_IN_I[BIT_SCAN_IN];
      input_level[BIT_SCAN_OUT]         = PAD_IN_I[BIT_SCAN_OUT];
   end

   // ========================================================================
   // Status to the functional logic
   always_comb
   begin
      // Functional logic sees the pads whether or not they are overridden
      FUNC_LEVEL_O      = PAD_IN_I;
      PIN_OVERRIDE_O    = override;
      // Clock output is off while its pin is overridden
      CLOCK_OUTPUT_ON_O = ~override[BIT_CLOCK_OUTPUT_PIN];
   end

endmodule

// ==== tb/pgo_board.sv ====
`timescale 1ns/10ps
module pgo_board
(
   input  wire pgo_pkg::pgo_pad_drive_t drive_i,
   input  wire logic [7:0]              ext_i,
   output logic      [7:0]              pad_o
);
   import pgo_pkg::*;
   // Board drives a pin only while the device has let go of it
   always_comb pad_o = (drive_i.level & ~drive_i.oe_n) | (ext_i & drive_i.oe_n);
endmodule

// ==== tb/pgo_props.sv ====
`timescale 1ns/10ps
module pgo_props
(
   input wire logic                       CLK_SYS_I,
   input wire logic                       NRST_I,
   input wire logic [pgo_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
   input wire logic                       AVS_READ_I,
   input wire logic                       AVS_WRITE_I,
   input wire logic [pgo_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
   input wire logic [3:0]                 AVS_BYTEENABLE_I,
   input wire logic [pgo_pkg::DATA_W-1:0] AVS_READDATA_O,
   input wire logic [1:0]                 AVS_RESPONSE_O,
   input wire logic                       AVS_WAITREQUEST_O,
   input wire logic                       SCAN_ACTIVE_I,
   input wire pgo_pkg::pgo_pad_drive_t    FUNC_DRIVE_I,
   input wire logic [pgo_pkg::PAD_N-1:0]  FUNC_LEVEL_O,
   input wire logic [pgo_pkg::PAD_N-1:0]  PIN_OVERRIDE_O,
   input wire logic                       CLOCK_OUTPUT_ON_O,
   input wire logic [pgo_pkg::PAD_N-1:0]  PAD_IN_I,
   input wire pgo_pkg::pgo_pad_drive_t    PAD_DRIVE_O
);
   import pgo_pkg::*;
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!NRST_I);
   // ========================================
   // Bus steps
   sequence s_take;
      (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
   endsequence
   sequence s_take_en;
      s_take ##0 AVS_WRITE_I && AVS_ADDRESS_I[8:2] == IDX_OUTPUT_ENABLE && AVS_BYTEENABLE_I[0];
   endsequence
   property p_one_wait;
      s_take |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("waitrequest not low for one cycle");
   property p_enable_write;
      s_take_en |=> ##1 PIN_OVERRIDE_O == ($past(AVS_WRITEDATA_I[7:0]) & (SCAN_ACTIVE_I ? 8'hF0 : 8'hFF));
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("override not from enable write");
   property p_read_in;
      s_take ##0 AVS_READ_I && AVS_ADDRESS_I[8:2] == IDX_INPUT_LEVEL |=> AVS_READDATA_O == {24'h0, $past(PAD_IN_I)};
   endproperty
   a_read_in: assert property (p_read_in) else $error("input read differs from pads");
   property p_unmapped;
      s_take ##0 (AVS_ADDRESS_I[8:2] < 7'h44 || AVS_ADDRESS_I[8:2] > 7'h46) |=> AVS_RESPONSE_O == 2'h3;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   // ========================================
   // Pads
   property p_oe;
      PAD_DRIVE_O.oe_n == (FUNC_DRIVE_I.oe_n & ~PIN_OVERRIDE_O);
   endproperty
   a_oe: assert property (p_oe) else $error("pad enable wrong");
   property p_func_level;
      (PAD_DRIVE_O.level & ~PIN_OVERRIDE_O) == (FUNC_DRIVE_I.level & ~PIN_OVERRIDE_O);
   endproperty
   a_func_level: assert property (p_func_level) else $error("function level lost");
   property p_scan_mask;
      SCAN_ACTIVE_I |-> (PIN_OVERRIDE_O & SCAN_PIN_MASK) == 8'h00;
   endproperty
   a_scan_mask: assert property (p_scan_mask) else $error("scan pins overridden");
   property p_clk_off;
      CLOCK_OUTPUT_ON_O == !PIN_OVERRIDE_O[6];
   endproperty
   a_clk_off: assert property (p_clk_off) else $error("clock output not switched off");
   property p_level_copy;
      FUNC_LEVEL_O == PAD_IN_I;
   endproperty
   a_level_copy: assert property (p_level_copy) else $error("function level copy wrong");
endmodule

// ==== tb/test_pad_gpio_override.sv ====
`timescale 1ns/10ps
module test_pad_gpio_override;
   import pgo_pkg::*;
   logic clk, nrst, rd, wr, wt, scan, ckon, hung;
   logic [8:0] adr;
   logic [31:0] wdat, rdat, got;
   logic [3:0] be, b;
   logic [1:0] rsp, gr;
   logic [7:0] flev, ovr, pin, ext, en, val, o, d, lv;
   pgo_pad_drive_t fdrv, pdrv;
   int failures, num_checks, m_en, m_val;
   pgo_top dut (.CLK_SYS_I(clk), .NRST_I(nrst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
      .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat), .AVS_RESPONSE_O(rsp),
      .AVS_WAITREQUEST_O(wt), .SCAN_ACTIVE_I(scan), .FUNC_DRIVE_I(fdrv), .FUNC_LEVEL_O(flev),
      .PIN_OVERRIDE_O(ovr), .CLOCK_OUTPUT_ON_O(ckon), .PAD_IN_I(pin), .PAD_DRIVE_O(pdrv));
   pgo_board board (.drive_i(pdrv), .ext_i(ext), .pad_o(pin));
   // ========================================
   // Tasks
   task test_done();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         failures++;
         $display("wrong value at %0t: got %h exp %h", $time, s, e);
      end
   endtask
   task bus(input logic w, input logic [8:0] a, input logic [7:0] dd, input logic [3:0] bb);
      int n;
      if (hung)
         return;
      @(posedge clk);
      adr <= a; rd <= !w; wr <= w; wdat <= {24'h0, dd}; be <= bb;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (wt !== 1'b0 && n < 20);
      if (wt !== 1'b0)
      begin
         failures++;
         hung = 1'b1;
      end
      got = rdat; gr = rsp;
      rd <= 1'b0; wr <= 1'b0;
   endtask
   // ========================================
   // Stimulus
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      nrst = 1'b0; rd = 1'b0; wr = 1'b0; adr = '0; wdat = '0; be = '0; scan = 1'b0; fdrv = '0; ext = '0;
      hung = 1'b0;
      void'($urandom(86));
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      bus(1'b0, 9'h110, 8'h00, 4'h1); chk(got, 32'h0);
      bus(1'b0, 9'h114, 8'h00, 4'h1); chk(got, 32'h0);
      bus(1'b0, 9'h11C, 8'h00, 4'h1); chk(32'(gr), 32'h3);
      m_en = 0; m_val = 0;
      for (int i = 0; i < 16 && !hung; i++)
      begin
         @(posedge clk);
         scan <= i[1]; fdrv <= 16'($urandom); ext <= 8'($urandom);
         en = (i == 0) ? 8'hFF : 8'($urandom);
         val = 8'($urandom);
         b = i[2] ? 4'hE : 4'h1;
         bus(1'b1, 9'h110, en, 4'h1);
         bus(1'b1, 9'h114, val, b);
         bus(1'b1, 9'h118, 8'hFF, 4'h1);
         m_en = en;
         if (b[0])
            m_val = val;
         bus(1'b0, 9'h110, 8'h00, 4'h1); chk(got, 32'(m_en));
         bus(1'b0, 9'h114, 8'h00, 4'h1); chk(got, 32'(m_val));
         o = 8'(m_en) & (scan ? 8'hF0 : 8'hFF);
         chk(32'(ovr), 32'(o));
         chk(32'(pdrv.oe_n), 32'(fdrv.oe_n & ~o));
         lv = (8'(m_val) & o) | (fdrv.level & ~o);
         chk(32'(pdrv.level), 32'(lv));
         chk(32'(ckon), 32'(!o[6]));
         d = ~(fdrv.oe_n & ~o);
         bus(1'b0, 9'h118, 8'h00, 4'h1); chk(got, 32'((lv & d) | (ext & ~d)));
      end
      // Reset in mid-run: registers clear, pins return to their functions
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      chk(32'(ovr), 32'h0);
      chk(32'(pdrv), 32'(fdrv));
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      bus(1'b0, 9'h110, 8'h00, 4'h1); chk(got, 32'h0);
      bus(1'b0, 9'h114, 8'h00, 4'h1); chk(got, 32'h0);
      test_done();
   end
endmodule
bind pgo_top pgo_props u_props (.CLK_SYS_I, .NRST_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_WRITEDATA_I,
   .AVS_BYTEENABLE_I, .AVS_READDATA_O, .AVS_RESPONSE_O, .AVS_WAITREQUEST_O, .SCAN_ACTIVE_I, .FUNC_DRIVE_I,
   .FUNC_LEVEL_O, .PIN_OVERRIDE_O, .CLOCK_OUTPUT_ON_O, .PAD_IN_I, .PAD_DRIVE_O);
